/* File: core/nce_execute.sv */
// Instruction sequencer and execute datapath of the nibble core
// What this block does
// (RL1) Memory load copies RAM nibble, sets zero
// (RL2) Swap-modify swaps, XORs pointer high, zero
// (RL3) Plain swap: zero from pointer high
// (RL4) Swap then step pointer low, zero
// (RL5) Table read: ROM page byte into accumulator, E
// (RL6) Pointer loads, steps and transfers
// (RL7) Working register swaps, no flag change
// (RL8) Flag set/clear; clear sets zero from group
// (RL9) Long jump keeps bit 11 unless bank
// (RL10) Indirect jump: low PC from E, accumulator
// (RL11) Zero page call pushes PC plus one
// (RL12) Bank zero call pushes PC plus two
// (RL13) Returns pop stack; irq return restores flags
// (RL14) In-page branches on bit or flag
// (RL15) Timer branches test, clear timer flag unless an event arrives that cycle
// (RL16) External branches test, clear flag unless an event arrives that cycle
// (RL17) Flag-bit branches on one of sixteen
// (RL18) Port in, out, bit set, bit clear
// (RL19) Control bits set or cleared by mask
// (RL20) Timer write loads timer, clears its flag
// (RL21) Halt enters standby
// (RL22) Repeated load-immediate runs as no-operation
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module nce_execute #(
  parameter int STACK_DEPTH = nce_pkg::STACK_DEPTH
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  output logic [11:0] rom_addr_o,
  input wire logic [7:0] rom_data_i,
  output nce_pkg::nce_ram_req_s ram_o,
  input wire logic [3:0] ram_rdata_i,
  output nce_pkg::nce_port_req_s port_o,
  input wire logic [3:0] port_rdata_i,
  input wire logic timer_event_i,
  input wire logic ext_event_i,
  output logic [7:0] timer_value_o,
  output logic timer_load_o,
  output logic halted_o,
  output logic [3:0] control_o,
  input wire logic [2:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o
);
  import nce_pkg::*;

  localparam int SP_W = $clog2(STACK_DEPTH);

  nce_state_e state;
  logic [11:0] pc;
  logic [7:0] op;
  logic [7:0] arg;
  logic op_two;
  logic [3:0] acc;
  logic [3:0] e_reg;
  logic [3:0] ph;
  logic [3:0] pl;
  logic [3:0] work_a [4];
  logic [3:0] work_h [2];
  logic [3:0] work_l [2];
  logic carry_flag;
  logic zero_flag;
  logic saved_carry;
  logic saved_zero;
  logic timer_request_flag;
  logic external_request_flag;
  logic [15:0] flags;
  logic [11:0] stack [STACK_DEPTH];
  logic [SP_W-1:0] sp;
  logic bank_pending;
  logic prev_li;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic is_two_byte(input logic [7:0] code);
    is_two_byte = (code[7:4] == BR_TRUE_HI) || (code[7:4] == BR_FALSE_HI)
      || (code[7:4] == FBR_TRUE_HI) || (code[7:4] == FBR_FALSE_HI)
      || (code[7:3] == OP_LONG_JUMP_HI) || (code[7:3] == OP_BANK0_CALL_HI)
      || (code == OP_CTRL_BITS);
  endfunction

  logic exec;
  logic is_li;
  logic do_li;
  logic is_branch;
  logic br_cond;
  logic br_taken;
  logic is_xm;
  logic [3:0] xm_ph;
  logic [3:0] pl_inc;
  logic [3:0] pl_dec;
  logic [3:0] bit_mask;
  logic [3:0] rfb_group;
  logic [3:0] port_clr_val;
  logic [11:0] pc_step;
  logic wake;

  always_comb begin
    exec = (state == ST_EXEC);
    is_li = (op[7:4] == OP_LOAD_IMMEDIATE_HI);
    do_li = is_li && !prev_li; // RL22
    is_xm = (op[7:3] == OP_SWAP_MEM_MODIFY_HI);
    xm_ph = ph ^ {1'b0, op[2:0]};
    pl_inc = pl + 4'h1;
    pl_dec = pl - 4'h1;
    bit_mask = 4'h1 << op[1:0];
    rfb_group = flags[{op[3:2], 2'b00} +: 4] & ~bit_mask;
    port_clr_val = port_rdata_i & ~bit_mask;
    pc_step = op_two ? pc + 12'h002 : pc + 12'h001;
    wake = reg_wr_i && (reg_addr_i == REG_WAKE) && reg_wdata_i[WAKE_BIT];
    is_branch = (op[7:4] == BR_TRUE_HI) || (op[7:4] == BR_FALSE_HI)
      || (op[7:4] == FBR_TRUE_HI) || (op[7:4] == FBR_FALSE_HI);
    br_cond = 1'b0;
    if (op[7:4] == FBR_TRUE_HI || op[7:4] == FBR_FALSE_HI) begin
      br_cond = flags[op[3:0]]; // RL17
    end else begin
      case (op[3:0])
        BR_SEL_TIMER: br_cond = timer_request_flag; // RL15
        BR_SEL_EXT: br_cond = external_request_flag; // RL16
        BR_SEL_ZERO: br_cond = zero_flag;
        BR_SEL_CARRY: br_cond = carry_flag;
        default: begin
          case (op[3:2])
            BR_SEL_ACC: br_cond = acc[op[1:0]];
            BR_SEL_MEM: br_cond = ram_rdata_i[op[1:0]];
            BR_SEL_PORT: br_cond = port_rdata_i[op[1:0]];
            default: br_cond = 1'b0;
          endcase
        end
      endcase
    end
    br_taken = is_branch && (br_cond == ((op[7:4] == BR_TRUE_HI)
      || (op[7:4] == FBR_TRUE_HI))); // RL14
  end

  // ----------------------------------------------------------------
  // Sequencer, program counter and stack
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state <= ST_FETCH;
      pc <= RESET_PC;
      op <= 8'h00;
      arg <= 8'h00;
      op_two <= 1'b0;
      rom_addr_o <= RESET_PC;
      sp <= '0;
      bank_pending <= 1'b0;
      prev_li <= 1'b0;
      halted_o <= 1'b0;
    end else if (ce_i) begin
      case (state)
        ST_FETCH: begin
          rom_addr_o <= pc;
          state <= ST_DECODE;
        end
        ST_DECODE: begin
          op <= rom_data_i;
          op_two <= is_two_byte(rom_data_i);
          if (is_two_byte(rom_data_i)) begin
            rom_addr_o <= pc + 12'h001;
            state <= ST_OPERAND;
          end else begin
            state <= ST_EXEC;
          end
        end
        ST_OPERAND: begin
          arg <= rom_data_i;
          state <= ST_EXEC;
        end
        ST_EXEC: begin
          pc <= pc_step;
          state <= ST_FETCH;
          bank_pending <= (op == OP_BANK_CHANGE);
          prev_li <= is_li;
          if (op[7:3] == OP_LONG_JUMP_HI) begin
            pc <= {pc[11] ^ bank_pending, op[2:0], arg}; // RL9
          end else if (op == OP_INDIRECT_PAGE_JUMP) begin
            pc <= {pc[11:8], e_reg, acc}; // RL10
          end else if (op[7:4] == OP_ZERO_PAGE_CALL_HI) begin
            stack[sp] <= pc + 12'h001; // RL11
            sp <= sp + 1'b1;
            pc <= {6'h00, op[3:0], 2'b00}; // RL11
          end else if (op[7:3] == OP_BANK0_CALL_HI) begin
            stack[sp] <= pc + 12'h002; // RL12
            sp <= sp + 1'b1;
            pc <= {1'b0, op[2:0], arg}; // RL12
          end else if (op == OP_SUB_RETURN || op == OP_IRQ_RETURN) begin
            pc <= stack[sp - 1'b1]; // RL13
            sp <= sp - 1'b1;
          end else if (br_taken) begin
            pc <= {pc[11:8], arg}; // RL14
          end else if (op == OP_TABLE_READ) begin
            rom_addr_o <= {pc[11:8], e_reg, acc}; // RL5
            state <= ST_TABLE;
          end else if (op == OP_HALT) begin
            halted_o <= 1'b1; // RL21
            state <= ST_HALT;
          end
        end
        ST_TABLE: begin
          state <= ST_FETCH;
        end
        ST_HALT: begin
          if (wake) begin
            halted_o <= 1'b0;
            state <= ST_FETCH;
          end
        end
        default: begin
          state <= ST_FETCH;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Accumulator, E, pointer, working registers, carry and zero
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      acc <= NIB_RESET;
      e_reg <= NIB_RESET;
      ph <= NIB_RESET;
      pl <= NIB_RESET;
      work_a <= '{default: NIB_RESET};
      work_h <= '{default: NIB_RESET};
      work_l <= '{default: NIB_RESET};
      carry_flag <= 1'b0;
      zero_flag <= 1'b0;
    end else if (ce_i) begin
      if (state == ST_TABLE) begin
        acc <= rom_data_i[3:0]; // RL5
        e_reg <= rom_data_i[7:4]; // RL5
      end else if (exec) begin
        if (op == OP_MEM_LOAD) begin
          acc <= ram_rdata_i; // RL1
          zero_flag <= (ram_rdata_i == 4'h0); // RL1
        end else if (is_xm) begin
          acc <= ram_rdata_i; // RL2
          ph <= xm_ph; // RL2
          zero_flag <= (xm_ph == 4'h0); // RL3
        end else if (op == OP_SWAP_MEM_INC) begin
          acc <= ram_rdata_i; // RL4
          pl <= pl_inc;
          zero_flag <= (pl_inc == 4'h0);
        end else if (op == OP_SWAP_MEM_DEC) begin
          acc <= ram_rdata_i; // RL4
          pl <= pl_dec;
          zero_flag <= (pl_dec == 4'h0);
        end else if (op[7:4] == OP_PTR_ZERO_LOAD_HI) begin
          ph <= 4'h0; // RL6
          pl <= op[3:0];
        end else if (op[7:4] == OP_PTR_HIGH_LOAD_HI) begin
          ph <= op[3:0]; // RL6
        end else if (op == OP_PTR_LOW_INC) begin
          pl <= pl_inc; // RL6
          zero_flag <= (pl_inc == 4'h0);
        end else if (op == OP_PTR_LOW_DEC) begin
          pl <= pl_dec; // RL6
          zero_flag <= (pl_dec == 4'h0);
        end else if (op == OP_ACC_TO_PTR_LOW) begin
          pl <= acc; // RL6
        end else if (op == OP_PTR_LOW_TO_ACC) begin
          acc <= pl; // RL6
          zero_flag <= (pl == 4'h0);
        end else if (op == OP_SWAP_ACC_PTR_HIGH) begin
          acc <= ph; // RL6
          ph <= acc;
        end else if (op[7:4] == OP_SWAP_ACC_WORK_HI
                     && op[1:0] == WORK_SEL_LOW) begin
          acc <= work_a[op[3:2]]; // RL7
          work_a[op[3:2]] <= acc;
        end else if (op[7:3] == OP_SWAP_PTR_HIGH_WORK_HI
                     && op[1:0] == WORK_SEL_LOW) begin
          ph <= work_h[op[2]]; // RL7
          work_h[op[2]] <= ph;
        end else if (op[7:3] == OP_SWAP_PTR_LOW_WORK_HI
                     && op[1:0] == WORK_SEL_LOW) begin
          pl <= work_l[op[2]]; // RL7
          work_l[op[2]] <= pl;
        end else if (op[7:4] == OP_FLAG_CLEAR_HI) begin
          zero_flag <= (rfb_group == 4'h0); // RL8
        end else if (op == OP_IRQ_RETURN) begin
          carry_flag <= saved_carry; // RL13
          zero_flag <= saved_zero;
        end else if (op == OP_PORT_IN) begin
          acc <= port_rdata_i; // RL18
          zero_flag <= (port_rdata_i == 4'h0);
        end else if (op[7:2] == OP_PORT_BIT_CLEAR_HI) begin
          e_reg <= port_clr_val; // RL18
          zero_flag <= (port_clr_val == 4'h0);
        end else if (op == OP_CTRL_BITS && arg[7:4] == CTRL_CLEAR_TAG) begin
          zero_flag <= ((control_o & ~arg[3:0]) == 4'h0);
        end else if (do_li) begin
          acc <= op[3:0]; // RL22
          zero_flag <= (op[3:0] == 4'h0);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Flag bits, request flags, control register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      flags <= FLAGS_RESET;
      timer_request_flag <= 1'b0;
      external_request_flag <= 1'b0;
      control_o <= CTRL_RESET;
      saved_carry <= 1'b0;
      saved_zero <= 1'b0;
    end else if (ce_i) begin
      if (reg_wr_i && reg_addr_i == REG_FLAGS) begin
        flags <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == REG_CTRL) begin
        control_o <= reg_wdata_i[3:0];
        saved_carry <= reg_wdata_i[CTRL_SAVED_CF_BIT];
        saved_zero <= reg_wdata_i[CTRL_SAVED_ZF_BIT];
      end
      if (exec && op[7:4] == OP_FLAG_SET_HI) begin
        flags[op[3:0]] <= 1'b1; // RL8
      end
      if (exec && op[7:4] == OP_FLAG_CLEAR_HI) begin
        flags[op[3:0]] <= 1'b0; // RL8
      end
      if (exec && op == OP_CTRL_BITS && arg[7:4] == CTRL_SET_TAG) begin
        control_o <= control_o | arg[3:0]; // RL19
      end
      if (exec && op == OP_CTRL_BITS && arg[7:4] == CTRL_CLEAR_TAG) begin
        control_o <= control_o & ~arg[3:0]; // RL19
      end
      // Event in the clearing cycle wins
      if (timer_event_i) begin
        timer_request_flag <= 1'b1;
      end else if (exec && (op == OP_TIMER_WRITE
          || (op[7:4] == BR_TRUE_HI || op[7:4] == BR_FALSE_HI)
          && op[3:0] == BR_SEL_TIMER)) begin
        timer_request_flag <= 1'b0; // RL15 RL20
      end
      if (ext_event_i) begin
        external_request_flag <= 1'b1;
      end else if (exec && (op[7:4] == BR_TRUE_HI || op[7:4] == BR_FALSE_HI)
          && op[3:0] == BR_SEL_EXT) begin
        external_request_flag <= 1'b0; // RL16
      end
    end
  end

  // ----------------------------------------------------------------
  // RAM, port and timer requests
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ram_o <= '0;
      port_o <= '0;
      timer_value_o <= 8'h00;
      timer_load_o <= 1'b0;
    end else if (ce_i) begin
      ram_o.we <= 1'b0;
      port_o.we <= 1'b0;
      timer_load_o <= 1'b0;
      if (state == ST_FETCH) begin
        ram_o.addr <= {ph, pl};
        port_o.addr <= pl; // RL18
      end
      if (exec && (is_xm || op == OP_SWAP_MEM_INC
          || op == OP_SWAP_MEM_DEC)) begin
        ram_o.wdata <= acc; // RL2 RL3 RL4
        ram_o.we <= 1'b1;
      end
      if (exec && op == OP_PORT_OUT) begin
        port_o.wdata <= acc; // RL18
        port_o.we <= 1'b1;
      end
      if (exec && op[7:2] == OP_PORT_BIT_SET_HI) begin
        port_o.wdata <= port_rdata_i | bit_mask; // RL18
        port_o.we <= 1'b1;
      end
      if (exec && op[7:2] == OP_PORT_BIT_CLEAR_HI) begin
        port_o.wdata <= port_clr_val; // RL18
        port_o.we <= 1'b1;
      end
      if (exec && op == OP_TIMER_WRITE) begin
        timer_value_o <= {e_reg, acc}; // RL20
        timer_load_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port read data
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (ce_i) begin
      reg_rdata_o <= 16'h0000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          REG_STATUS: reg_rdata_o <= {carry_flag, zero_flag,
            timer_request_flag, external_request_flag, ph, e_reg, acc};
          REG_PC: reg_rdata_o <= {4'h0, pc};
          REG_CTRL: reg_rdata_o <= {10'h000, saved_zero, saved_carry,
            control_o};
          REG_FLAGS: reg_rdata_o <= flags;
          REG_WAKE: reg_rdata_o <= {15'h0000, halted_o};
          default: reg_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

endmodule

/* File: core/nce_pkg.sv */
// Shared constants and types of the nibble core execute block
package nce_pkg;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 8;
  localparam logic [11:0] RESET_PC = 12'h000;
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Register port offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_PC = 3'h1;
  localparam logic [2:0] REG_CTRL = 3'h2;
  localparam logic [2:0] REG_FLAGS = 3'h3;
  localparam logic [2:0] REG_WAKE = 3'h4;
  localparam int CTRL_SAVED_CF_BIT = 4;
  localparam int CTRL_SAVED_ZF_BIT = 5;
  localparam int WAKE_BIT = 0;

  // ----------------------------------------------------------------
  // Opcodes and opcode fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_MEM_LOAD = 8'h21;
  localparam logic [4:0] OP_SWAP_MEM_MODIFY_HI = 5'h14;
  localparam logic [7:0] OP_SWAP_MEM_INC = 8'hfe;
  localparam logic [7:0] OP_SWAP_MEM_DEC = 8'hff;
  localparam logic [7:0] OP_TABLE_READ = 8'h63;
  localparam logic [3:0] OP_PTR_ZERO_LOAD_HI = 4'h8;
  localparam logic [3:0] OP_PTR_HIGH_LOAD_HI = 4'h4;
  localparam logic [7:0] OP_PTR_LOW_INC = 8'hee;
  localparam logic [7:0] OP_PTR_LOW_DEC = 8'hef;
  localparam logic [7:0] OP_ACC_TO_PTR_LOW = 8'hf7;
  localparam logic [7:0] OP_PTR_LOW_TO_ACC = 8'he9;
  localparam logic [7:0] OP_SWAP_ACC_PTR_HIGH = 8'h23;
  localparam logic [3:0] OP_SWAP_ACC_WORK_HI = 4'he;
  localparam logic [4:0] OP_SWAP_PTR_HIGH_WORK_HI = 5'h1f;
  localparam logic [4:0] OP_SWAP_PTR_LOW_WORK_HI = 5'h1e;
  localparam logic [1:0] WORK_SEL_LOW = 2'b00;
  localparam logic [3:0] OP_FLAG_SET_HI = 4'h5;
  localparam logic [3:0] OP_FLAG_CLEAR_HI = 4'h1;
  localparam logic [4:0] OP_LONG_JUMP_HI = 5'h0d;
  localparam logic [7:0] OP_INDIRECT_PAGE_JUMP = 8'hfa;
  localparam logic [3:0] OP_ZERO_PAGE_CALL_HI = 4'hb;
  localparam logic [4:0] OP_BANK0_CALL_HI = 5'h15;
  localparam logic [7:0] OP_SUB_RETURN = 8'h62;
  localparam logic [7:0] OP_IRQ_RETURN = 8'h22;
  localparam logic [7:0] OP_BANK_CHANGE = 8'hfd;
  localparam logic [3:0] BR_TRUE_HI = 4'h7;
  localparam logic [3:0] BR_FALSE_HI = 4'h3;
  localparam logic [3:0] FBR_TRUE_HI = 4'hd;
  localparam logic [3:0] FBR_FALSE_HI = 4'h9;
  localparam logic [1:0] BR_SEL_ACC = 2'b00;
  localparam logic [1:0] BR_SEL_MEM = 2'b01;
  localparam logic [1:0] BR_SEL_PORT = 2'b10;
  localparam logic [3:0] BR_SEL_TIMER = 4'hc;
  localparam logic [3:0] BR_SEL_EXT = 4'hd;
  localparam logic [3:0] BR_SEL_ZERO = 4'he;
  localparam logic [3:0] BR_SEL_CARRY = 4'hf;
  localparam logic [7:0] OP_PORT_IN = 8'h0c;
  localparam logic [7:0] OP_PORT_OUT = 8'h61;
  localparam logic [5:0] OP_PORT_BIT_SET_HI = 6'h01;
  localparam logic [5:0] OP_PORT_BIT_CLEAR_HI = 6'h09;
  localparam logic [7:0] OP_CTRL_BITS = 8'h2c;
  localparam logic [3:0] CTRL_SET_TAG = 4'h8;
  localparam logic [3:0] CTRL_CLEAR_TAG = 4'h9;
  localparam logic [7:0] OP_TIMER_WRITE = 8'hf9;
  localparam logic [7:0] OP_HALT = 8'hf6;
  localparam logic [3:0] OP_LOAD_IMMEDIATE_HI = 4'hc;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_DECODE = 3'b001,
    ST_OPERAND = 3'b010,
    ST_EXEC = 3'b011,
    ST_TABLE = 3'b100,
    ST_HALT = 3'b101
  } nce_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] wdata;
    logic we;
  } nce_ram_req_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [3:0] wdata;
    logic we;
  } nce_port_req_s;

endpackage

/* File: test/nce_execute_assertions.sv */
// Port checks of the execute block
`timescale 1ns/1ps
module nce_execute_checker
  import nce_pkg::*;
#(
  parameter int STACK_DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire nce_pkg::nce_ram_req_s ram_o,
  input wire nce_pkg::nce_port_req_s port_o,
  input wire logic timer_load_o,
  input wire logic halted_o,
  input wire logic [3:0] control_o,
  input wire logic [2:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i || !ce_i);

  property p_rd_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_unmapped;
    reg_rd_i && reg_addr_i > REG_WAKE |=> reg_rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_pc_top;
    reg_rd_i && reg_addr_i == REG_PC |=> reg_rdata_o[15:12] == 4'h0;
  endproperty
  a_pc_top: assert property (p_pc_top)
    else $error("pc wider than twelve bits");
  property p_ram_we;
    ram_o.we |=> !ram_o.we;
  endproperty
  a_ram_we: assert property (p_ram_we)
    else $error("ram write longer than one cycle");
  property p_port_we;
    port_o.we |=> !port_o.we;
  endproperty
  a_port_we: assert property (p_port_we)
    else $error("port write longer than one cycle");
  property p_tload;
    timer_load_o |=> !timer_load_o;
  endproperty
  a_tload: assert property (p_tload)
    else $error("timer load longer than one cycle");
  property p_halt_hold;
    halted_o && !reg_wr_i |=> halted_o && !ram_o.we && !port_o.we;
  endproperty
  a_halt_hold: assert property (p_halt_hold)
    else $error("activity while halted");
  property p_halt_ctrl;
    halted_o && !reg_wr_i |=> $stable(control_o);
  endproperty
  a_halt_ctrl: assert property (p_halt_ctrl)
    else $error("control changed while halted");
  property p_wake;
    halted_o && reg_wr_i && reg_addr_i == REG_WAKE && reg_wdata_i[0]
      |-> ##[1:2] !halted_o;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake from standby");

  c_tload: cover property (timer_load_o);
  c_port_we: cover property (port_o.we);
  c_halt: cover property ($rose(halted_o));
endmodule

bind nce_execute nce_execute_checker #(.STACK_DEPTH(STACK_DEPTH)) chk (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
  .ram_o(ram_o), .port_o(port_o), .timer_load_o(timer_load_o),
  .halted_o(halted_o), .control_o(control_o), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o)
);

/* File: test/nce_mem_model.sv */
// Program ROM, data RAM and port latches seen by the execute block
`timescale 1ns/1ps
module nce_mem_model
  import nce_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic [11:0] rom_addr_i,
  output logic [7:0] rom_data_o,
  input wire nce_pkg::nce_ram_req_s ram_i,
  output logic [3:0] ram_rdata_o,
  input wire nce_pkg::nce_port_req_s port_i,
  output logic [3:0] port_rdata_o
);
  logic [7:0] rom [4096];
  logic [3:0] ram [256];
  logic [3:0] port_q [16];

  // Asynchronous reads, as the core expects
  assign rom_data_o = rom[rom_addr_i];
  assign ram_rdata_o = ram[ram_i.addr];
  assign port_rdata_o = port_q[port_i.addr];

  always @(posedge core_clk_i) begin
    if (ram_i.we === 1'b1)
      ram[ram_i.addr] <= ram_i.wdata;
    if (port_i.we === 1'b1)
      port_q[port_i.addr] <= port_i.wdata;
  end
endmodule

/* File: test/test_nibble_cpu_instruction_execute.sv */
// Self-checking bench of the execute block
`timescale 1ns/1ps
module test_nibble_cpu_instruction_execute;
  import nce_pkg::*;
  logic core_clk_i, resetn_i, ce_i, timer_event_i, ext_event_i;
  logic reg_wr_i, reg_rd_i, timer_load_o, halted_o;
  logic [2:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, d;
  logic [11:0] rom_addr_o;
  logic [7:0] rom_data_i, timer_value_o;
  logic [3:0] ram_rdata_i, port_rdata_i, control_o;
  nce_ram_req_s ram_o;
  nce_port_req_s port_o;
  int mismatches, checks_done, loads;

  nce_execute DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .ce_i(ce_i), .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
    .ram_o(ram_o), .ram_rdata_i(ram_rdata_i), .port_o(port_o),
    .port_rdata_i(port_rdata_i), .timer_event_i(timer_event_i),
    .ext_event_i(ext_event_i), .timer_value_o(timer_value_o),
    .timer_load_o(timer_load_o), .halted_o(halted_o),
    .control_o(control_o), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o));
  nce_mem_model MEM (.core_clk_i(core_clk_i), .rom_addr_i(rom_addr_o),
    .rom_data_o(rom_data_i), .ram_i(ram_o), .ram_rdata_o(ram_rdata_i),
    .port_i(port_o), .port_rdata_o(port_rdata_i));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp, input string w);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task hold;
    resetn_i <= 1'b0;
    loads = 0;
    for (int i = 0; i < 4096; i++)
      MEM.rom[i] = 8'h00;
    for (int i = 0; i < 256; i++)
      MEM.ram[i] = 4'h0;
    for (int i = 0; i < 16; i++)
      MEM.port_q[i] = 4'h0;
  endtask
  task prog(input logic [11:0] a, input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++)
      MEM.rom[a + i] = b[i];
  endtask
  task go;
    repeat (6) @(posedge core_clk_i);
    resetn_i <= 1'b1;
  endtask
  task wait_halt;
    int n;
    n = 0;
    while (halted_o !== 1'b1 && n < 400) begin
      @(posedge core_clk_i);
      n++;
    end
    chk({15'h0, halted_o}, 16'h0001, "standby");
  endtask
  task wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_swap;
    hold;
    prog(0, {8'h83, 8'h21, 8'h61, 8'hc9, 8'hfe, 8'h61, 8'hff, 8'h61, 8'hf6});
    MEM.ram[3] = 4'h5;
    MEM.ram[4] = 4'ha;
    go;
    wait_halt;
    chk({12'h0, MEM.port_q[4]}, 16'h0005, "load then swap up");
    chk({12'h0, MEM.port_q[3]}, 16'h000a, "swap down");
    chk({12'h0, MEM.ram[3]}, 16'h0009, "ram 3");
    chk({12'h0, MEM.ram[4]}, 16'h0005, "ram 4");
    $display("t_swap done");
  endtask
  task t_table;
    hold;
    prog(0, {8'hc7, 8'h63, 8'hf9, 8'hfa, 8'h00, 8'h00, 8'h00, 8'h5a});
    prog(12'h05a, {8'hf6});
    go;
    wait_halt;
    chk({8'h0, timer_value_o}, 16'h005a, "table to timer");
    chk(16'(loads), 16'h0001, "timer loads");
    rd(REG_PC, d);
    chk(d, 16'h005b, "indirect jump");
    $display("t_table done");
  endtask
  task t_flags;
    hold;
    prog(0, {8'hc3, 8'hc6, 8'h61, 8'h55, 8'hd5, 8'h10, 8'hf6});
    prog(12'h010, {8'h10, 8'hf6});
    go;
    wait_halt;
    chk({12'h0, MEM.port_q[0]}, 16'h0003, "repeat load");
    rd(REG_STATUS, d);
    chk(d >> 14, 16'h1, "zero");
    rd(REG_PC, d);
    chk(d, 16'h0012, "flag branch");
    rd(REG_FLAGS, d);
    chk(d, 16'h0020, "flag set");
    $display("t_flags done");
  endtask
  task t_calls;
    hold;
    prog(0, {8'hb1, 8'hfd, 8'h68, 8'h20, 8'hc5, 8'h61, 8'h62});
    prog(12'h820, {8'ha8, 8'h30});
    prog(12'h030, {8'hf6});
    go;
    wait_halt;
    chk({12'h0, MEM.port_q[0]}, 16'h0005, "zero page call");
    rd(REG_PC, d);
    chk(d, 16'h0031, "bank jump then call");
    $display("t_calls done");
  endtask
  task t_events;
    hold;
    prog(0, {8'h00, 8'h7c, 8'h10});
    prog(12'h010, {8'h3d, 8'h20, 8'h2c, 8'h8b, 8'h2c, 8'h92, 8'h7c, 8'h30});
    prog(12'h018, {8'hf6});
    prog(12'h020, {8'hf6});
    prog(12'h030, {8'hf6});
    go;
    @(posedge core_clk_i);
    timer_event_i <= 1'b1;
    ext_event_i <= 1'b1;
    @(posedge core_clk_i);
    timer_event_i <= 1'b0;
    ext_event_i <= 1'b0;
    wait_halt;
    rd(REG_PC, d);
    chk(d, 16'h0019, "event branches");
    chk({12'h0, control_o}, 16'h0009, "control mask");
    wr(REG_CTRL, 16'h0006);
    rd(REG_CTRL, d);
    chk(d, 16'h0006, "control by bus");
    rd(3'h7, d);
    chk(d, 16'h0000, "unmapped");
    wr(REG_WAKE, 16'h0001);
    repeat (2) @(posedge core_clk_i);
    chk({15'h0, halted_o}, 16'h0000, "wake");
    $display("t_events done");
  endtask

  // ----------------------------------------------------------------
  // Clock, monitor, sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
    if (timer_load_o === 1'b1)
      loads++;
  initial begin
    repeat (20000) @(posedge core_clk_i);
    mismatches++;
    $display("[ERR] %0t run too long", $time);
    test_done;
  end
  initial begin
    resetn_i = 1'b0;
    ce_i = 1'b1;
    timer_event_i = 1'b0;
    ext_event_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 3'h0;
    reg_wdata_i = 16'h0000;
    mismatches = 0;
    checks_done = 0;
    t_swap;
    t_table;
    t_flags;
    t_calls;
    t_events;
    test_done;
  end
endmodule
